/* inc/two_wire_pkg.sv */
// two-wire master, transmit and receive: register map, field layout, status codes,
// reset values and bit timing shared by the block and its bench.
// assumes a 20 MHz system clock and an Avalon-MM master with 32-bit data.
package two_wire_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [4:0] OFF_CONTROL    = 5'h00;
    localparam logic [4:0] OFF_STATUS     = 5'h04;
    localparam logic [4:0] OFF_DATA       = 5'h08;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] OFF_IRQ_MASK   = 5'h10;

    // ==========================================================
    // control register bit positions
    localparam int BIT_DONE    = 7;
    localparam int BIT_ACK_EN  = 6;
    localparam int BIT_START   = 5;
    localparam int BIT_STOP    = 4;
    localparam int BIT_WCOL    = 3;
    localparam int BIT_ENABLE  = 2;
    localparam int BIT_IRQ_EN  = 0;

    // ==========================================================
    // interrupt status and mask layout
    localparam int IRQ_W    = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ARB  = 1;
    localparam int IRQ_WCOL = 2;

    // ==========================================================
    // status codes, prescaler bits zero
    localparam logic [7:0] CODE_START      = 8'h08;
    localparam logic [7:0] CODE_RSTART     = 8'h10;
    localparam logic [7:0] CODE_ADDR_ACK   = 8'h18;
    localparam logic [7:0] CODE_ADDR_NACK  = 8'h20;
    localparam logic [7:0] CODE_DATA_ACK   = 8'h28;
    localparam logic [7:0] CODE_DATA_NACK  = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST   = 8'h38;
    localparam logic [7:0] CODE_RADDR_ACK  = 8'h40;
    localparam logic [7:0] CODE_RADDR_NACK = 8'h48;
    localparam logic [7:0] CODE_RDATA_ACK  = 8'h50;
    localparam logic [7:0] CODE_RDATA_NACK = 8'h58;
    localparam logic [7:0] CODE_IDLE       = 8'hF8;
    localparam logic [7:0] CODE_MASK       = 8'hF8;

    // ==========================================================
    // reset values
    localparam logic [7:0]       CONTROL_RESET = 8'h00;
    localparam logic [1:0]       PRESC_RESET   = 2'h0;
    localparam logic [7:0]       DATA_RESET    = 8'hFF;
    localparam logic [IRQ_W-1:0] MASK_RESET    = 3'h0;

    // ==========================================================
    // timing: one quarter of a bus bit, least time, rounded up
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SCL_QUARTER_NS = 2500;
    localparam int QUARTER_CYCLES =
        (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_BITS      = 8;

endpackage : two_wire_pkg

/* testbench/two_wire_master_sva.sv */
// checker: bus handshake and pin order of the two-wire master.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
// ==== checker
module two_wire_master_sva (
    // bus side
    input wire logic        clk, reset_n, read, write, waitrequest,
    input wire logic [4:0]  address,
    input wire logic [31:0] writedata, readdata,
    // pins
    input wire logic        scl_oe, sda_oe, irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // exactly one wait cycle per access
    a_wait_first: assert property ($rose(read | write) |-> waitrequest) else $error("no wait");
    a_wait_once: assert property ((read | write) && waitrequest |=> !waitrequest)
        else $error("long wait");
    a_idle_nowait: assert property (!read && !write |-> !waitrequest) else $error("idle wait");
    // eight-bit registers, zero off the map
    a_high_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("high bits");
    a_unmapped: assert property (read && !waitrequest && address > 5'h10 |-> readdata == 0)
        else $error("unmapped");
    // start request on a free bus pulls data low soon
    a_start_req: assert property (write && !waitrequest && address == 5'h00 && writedata[7]
        && writedata[5] && writedata[2] && !writedata[4] && !scl_oe && !sda_oe
        |-> ##[1:20] sda_oe) else $error("no start");
    // data falls first on start, rises last on stop
    a_start_order: assert property ($rose(sda_oe) && !scl_oe |=> !scl_oe)
        else $error("start order");
    a_stop_idle: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe [*4])
        else $error("stop order");
    // parked: clock held low until software writes
    a_park_scl: assert property (irq && scl_oe && !write |=> scl_oe)
        else $error("park");
    c_start: cover property ($rose(sda_oe) && !scl_oe);
    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (read && !waitrequest && address > 5'h10);
endmodule : two_wire_master_sva
bind two_wire_master two_wire_master_sva two_wire_master_sva_i (.*);
`default_nettype wire

/* testbench/two_wire_master_tb.sv */
// bench: two-wire master against a slave model, registers and byte flow.
// assumes package, design and slave model compiled first.
`timescale 1ns/1ps
`default_nettype none
// ==== bench
module two_wire_master_tb;
    import two_wire_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
    logic        nack = 1'b0, stretch = 1'b0, waitrequest, scl_oe, sda_oe, irq;
    logic        scl_pull, sda_pull, scl_o, sda_o;
    logic [4:0]  address = 5'h00;
    logic [7:0]  last_byte, d;
    logic [31:0] writedata = 32'h0, readdata, q;
    int          errors = 0, n_checks = 0, t;
    // released lines float high through the pull-ups
    wire logic   scl = (scl_oe ? scl_o : 1'b1) & !scl_pull;
    wire logic   sda = (sda_oe ? sda_o : 1'b1) & !sda_pull;
    // op addr data: 0 wr, 1 status, 2 wait done, 3 reg, 4 poll, 5 heard, 6 knobs, 7 irq
    logic [19:0] rows [] = '{
        20'h3_00_00, 20'h3_04_F8, 20'h3_08_FF, 20'h3_0C_00, 20'h3_10_00,
        20'h0_18_FF, 20'h3_18_00, 20'h7_00_00, 20'h0_00_A5, 20'h2_00_00, 20'h1_04_08,
        20'h7_00_01, 20'h0_08_A4, 20'h0_00_85, 20'h2_00_00, 20'h1_04_18, 20'h5_00_A4,
        20'h0_08_5A, 20'h0_00_85, 20'h0_08_33, 20'h2_00_00, 20'h1_04_28,
        20'h5_00_5A, 20'h3_00_8D, 20'h6_00_01, 20'h0_08_11, 20'h0_00_85,
        20'h2_00_00, 20'h1_04_30, 20'h6_00_02, 20'h0_00_A5, 20'h2_00_00, 20'h1_04_10,
        20'h0_08_A6, 20'h0_00_85, 20'h2_00_00, 20'h1_04_18, 20'h5_00_A6,
        20'h0_00_95, 20'h4_00_10, 20'h3_00_05, 20'h7_00_00,
        20'h0_10_01, 20'h7_00_01, 20'h0_0C_01, 20'h7_00_00, 20'h3_0C_04,
        20'h0_04_01, 20'h3_04_19};
    // 20 MHz clock
    always #25 clk = ~clk;
    two_wire_master #(.QUARTER(2)) two_wire_master_i (.clk, .reset_n, .address, .read,
        .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .scl_in(scl),
        .scl_out(scl_o), .scl_oe, .sda_in(sda), .sda_out(sda_o), .sda_oe, .irq);
    two_wire_slave_model two_wire_slave_model_i (.scl, .sda, .nack, .stretch, .scl_pull,
        .sda_pull, .last_byte);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one access: hold until waitrequest low, then release for a cycle
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, wd};
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // watchdog, far beyond the expected run
    initial begin
        #2000000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            d = rows[i][7:0];
            t = 0;
            case (rows[i][19:16])
                4'h0: bus(1'b1, rows[i][12:8], d);
                4'h1, 4'h3: bus(1'b0, rows[i][12:8], d);
                4'h2: while (irq !== 1'b1 && t++ < 4000) @(posedge clk);
                4'h4: do bus(1'b0, rows[i][12:8], d); while ((q[7:0] & d) != 0 && t++ < 50);
                4'h6: {stretch, nack} <= d[1:0];
                default: ;
            endcase
            // compare what the row expects
            case (rows[i][19:16])
                4'h1: chk("status", d, q & CODE_MASK);
                4'h2: chk("done", 1, irq);
                4'h3: chk("register", d, q);
                4'h4: chk("poll", 0, q[7:0] & d);
                4'h5: chk("heard", d, last_byte);
                4'h7: chk("irq", d, irq);
                default: ;
            endcase
        end
        // second reset after the last row, bus idle
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, OFF_STATUS, 8'h00);
        chk("status", CODE_IDLE, q);
        give_verdict();
    end
endmodule : two_wire_master_tb
`default_nettype wire

/* testbench/two_wire_slave_model.sv */
// slave receiver on the two-wire bus: acks or nacks, may stretch the clock.
// assumes open-drain lines resolved by the bench with pull-ups.
`timescale 1ns/1ps
`default_nettype none
// ==== slave model
module two_wire_slave_model (
    // resolved lines and knobs
    input  wire logic      scl, sda, nack, stretch,
    // pulls and last byte heard
    output var logic       scl_pull, sda_pull,
    output var logic [7:0] last_byte
);
    int         bit_n = -1;
    logic [7:0] shift_reg = 8'h00;
    initial scl_pull = 1'b0;
    initial sda_pull = 1'b0;
    // start or repeated start restarts the count
    always @(negedge sda) if (scl) bit_n = 0;
    // stop: quiet until next start
    always @(posedge sda) if (scl) bit_n = -1;
    // sample while clock high, msb first
    always @(posedge scl) if (bit_n >= 0 && bit_n < 8) begin
        shift_reg = {shift_reg[6:0], sda};
        bit_n++;
    end
    // ack on ninth bit; stretch mid-byte to be slow
    always @(negedge scl) begin
        if (bit_n == 8) begin
            last_byte = shift_reg;
            sda_pull = !nack;
            bit_n = 9;
        end else if (bit_n == 9) begin
            sda_pull = 1'b0;
            bit_n = 0;
        end else if (stretch && bit_n == 4) begin
            scl_pull = 1'b1;
            #600 scl_pull = 1'b0;
        end
    end
endmodule : two_wire_slave_model
`default_nettype wire

/* verilog/two_wire_master.sv */
// two-wire master: control, status and data registers behind an
// Avalon-MM slave, START / address / data / STOP engine on the pins.
// assumes open-drain pins resolved outside; pins come in asynchronous.
`timescale 1ns/1ps
`default_nettype none

module two_wire_master #(
    parameter int QUARTER = two_wire_pkg::QUARTER_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // clock line, open drain
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    // data line, open drain
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // interrupt
    output logic             irq
);
    import two_wire_pkg::*;

    // slowest divider must fit the 12-bit counter; a bad value stops
    // elaboration rather than wrapping the divider at run time
    if (QUARTER < 1 || QUARTER > 64) begin : g_bad_quarter
        $error("QUARTER out of range 1..64");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_FREE, ST_START, ST_RSTART,
        ST_BYTE, ST_HOLD, ST_STOP
    } state_e;

    typedef struct packed {
        state_e           state;
        logic [1:0]       ph;
        logic [11:0]      cnt;
        logic [3:0]       bitn;
        logic [7:0]       shift;
        logic             tx;
        logic             nack;
        logic             done;
        logic             ack_en;
        logic             start_req;
        logic             stop_req;
        logic             wcol;
        logic             enable;
        logic             irq_en;
        logic [7:0]       code;
        logic [1:0]       presc;
        logic [7:0]       data;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic             ack;
        logic [31:0]      rdata;
        logic             busy;
        logic             scl_prev;
        logic             sda_prev;
        logic             owner;
        logic             addr_phase;
        logic             rx_mode;
        logic             scl_drive;
        logic             sda_drive;
    } master_s;

    master_s    r_reg;
    master_s    r_next;
    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic [11:0] limit;
    logic       tick;
    logic       wait_scl;
    logic       wr;

    // ==========================================================
    // pin synchronisers
    two_wire_sync #(.WIDTH(2)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({scl_in, sda_in}),
        .q       (pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // quarter-bit length grows by four per prescaler step
    function automatic logic [11:0] quarter_limit(input logic [1:0] p);
        logic [11:0] base;
        base = 12'(QUARTER);
        return 12'(base << {p, 1'b0}) - 12'h001;
    endfunction : quarter_limit

    // ==========================================================
    // bit timing; a stretched clock holds the count at zero
    assign limit    = quarter_limit(r_reg.presc);
    assign tick     = (r_reg.cnt == limit);
    assign wait_scl = (r_reg.ph == 2'd2) && !scl_s &&
                      (r_reg.state == ST_BYTE || r_reg.state == ST_RSTART ||
                       r_reg.state == ST_STOP);
    assign wr       = write && r_reg.ack && byteenable[0];

    // ==========================================================
    // next state: bus slave, registers, bus watcher, engine
    always_comb begin
        logic [IRQ_W-1:0] ev;
        ev     = '0;
        r_next = r_reg;

        // one wait cycle per access, data from a flop
        r_next.ack = (read || write) && !r_reg.ack;
        if (read && !r_reg.ack) begin
            unique case (address)
                OFF_CONTROL:    r_next.rdata = {24'h0, r_reg.done, r_reg.ack_en,
                                    r_reg.start_req, r_reg.stop_req, r_reg.wcol,
                                    r_reg.enable, 1'b0, r_reg.irq_en};
                OFF_STATUS:     r_next.rdata = {24'h0, r_reg.code[7:3], 1'b0,
                                    r_reg.presc};
                OFF_DATA:       r_next.rdata = {24'h0, r_reg.data};
                OFF_IRQ_STATUS: r_next.rdata = {29'h0, r_reg.irq_status};
                OFF_IRQ_MASK:   r_next.rdata = {29'h0, r_reg.irq_mask};
                default:        r_next.rdata = 32'h0000_0000;
            endcase
        end

        // register writes take effect on the accepting edge
        if (wr) begin
            unique case (address)
                OFF_CONTROL: begin
                    if (writedata[BIT_DONE]) begin
                        r_next.done = 1'b0;
                    end
                    r_next.ack_en    = writedata[BIT_ACK_EN];
                    r_next.start_req = writedata[BIT_START];
                    r_next.stop_req  = writedata[BIT_STOP];
                    r_next.enable    = writedata[BIT_ENABLE];
                    r_next.irq_en    = writedata[BIT_IRQ_EN];
                end
                OFF_STATUS: r_next.presc = writedata[1:0];
                OFF_DATA: begin
                    if (r_reg.done) begin
                        r_next.data = writedata[7:0];
                        r_next.wcol = 1'b0;
                    end else begin
                        r_next.wcol   = 1'b1;
                        ev[IRQ_WCOL] = 1'b1;
                    end
                end
                OFF_IRQ_STATUS: r_next.irq_status = r_reg.irq_status & ~writedata[2:0];
                OFF_IRQ_MASK:   r_next.irq_mask   = writedata[2:0];
                default: ;
            endcase
        end

        // bus watcher: busy from any START until any STOP
        r_next.scl_prev = scl_s;
        r_next.sda_prev = sda_s;
        if (scl_s && r_reg.scl_prev && r_reg.sda_prev && !sda_s) begin
            r_next.busy = 1'b1;
        end else if (scl_s && r_reg.scl_prev && !r_reg.sda_prev && sda_s) begin
            r_next.busy = 1'b0;
        end

        // divider runs only while a timed step is under way
        if (r_reg.state == ST_IDLE || r_reg.state == ST_HOLD ||
            r_reg.state == ST_WAIT_FREE || wait_scl || tick) begin
            r_next.cnt = 12'h000;
        end else begin
            r_next.cnt = r_reg.cnt + 12'h001;
        end
        if (tick) begin
            r_next.ph = r_reg.ph + 2'd1;
        end

        unique case (r_reg.state)
            ST_IDLE: begin
                if (r_reg.enable && r_reg.start_req && !r_reg.done) begin
                    r_next.state = ST_WAIT_FREE;
                end
            end
            ST_WAIT_FREE: begin
                // start only on a quiet bus with both lines high
                if (!r_reg.busy && scl_s && sda_s) begin
                    r_next.state = ST_START;
                    r_next.ph    = 2'd0;
                end
            end
            ST_START: begin
                if (tick && r_reg.ph == 2'd0) begin
                    r_next.sda_drive = 1'b1;
                end else if (tick) begin
                    r_next.scl_drive  = 1'b1;
                    r_next.state      = ST_HOLD;
                    r_next.done       = 1'b1;
                    ev[IRQ_DONE]      = 1'b1;
                    r_next.code       = r_reg.owner ? CODE_RSTART : CODE_START;
                    r_next.owner      = 1'b1;
                    r_next.addr_phase = 1'b1;
                end
            end
            ST_RSTART: begin
                // release data while clock low, raise clock, then START
                if (tick) begin
                    unique case (r_reg.ph)
                        2'd0: r_next.sda_drive = 1'b0;
                        2'd1: r_next.scl_drive = 1'b0;
                        2'd2: ;
                        2'd3: begin
                            r_next.state = ST_START;
                            r_next.ph    = 2'd0;
                        end
                    endcase
                end
            end
            ST_BYTE: begin
                if (tick) begin
                    unique case (r_reg.ph)
                        2'd0: begin
                            // low drives 0: write bit and ack; release for 1
                            if (r_reg.bitn == 4'(BYTE_BITS)) begin
                                r_next.sda_drive = !r_reg.tx && r_reg.ack_en;
                            end else begin
                                r_next.sda_drive = r_reg.tx && !r_reg.shift[7];
                            end
                        end
                        2'd1: r_next.scl_drive = 1'b0;
                        2'd2: begin
                            if (r_reg.bitn == 4'(BYTE_BITS)) begin
                                r_next.nack = sda_s;
                            end else if (!r_reg.tx) begin
                                r_next.shift = {r_reg.shift[6:0], sda_s};
                            end else if (!r_reg.sda_drive && !sda_s) begin
                                // another master pulled a released line low
                                r_next.state     = ST_HOLD;
                                r_next.scl_drive = 1'b0;
                                r_next.sda_drive = 1'b0;
                                r_next.code      = CODE_ARB_LOST;
                                r_next.done      = 1'b1;
                                r_next.owner     = 1'b0;
                                ev[IRQ_DONE]     = 1'b1;
                                ev[IRQ_ARB]      = 1'b1;
                            end
                        end
                        2'd3: begin
                            r_next.scl_drive = 1'b1;
                            if (r_reg.bitn == 4'(BYTE_BITS)) begin
                                r_next.state      = ST_HOLD;
                                r_next.done       = 1'b1;
                                ev[IRQ_DONE]      = 1'b1;
                                r_next.addr_phase = 1'b0;
                                if (r_reg.addr_phase) begin
                                    if (r_reg.rx_mode) begin
                                        r_next.code = r_reg.nack ? CODE_RADDR_NACK
                                                                 : CODE_RADDR_ACK;
                                    end else begin
                                        r_next.code = r_reg.nack ? CODE_ADDR_NACK
                                                                 : CODE_ADDR_ACK;
                                    end
                                end else if (r_reg.tx) begin
                                    r_next.code = r_reg.nack ? CODE_DATA_NACK
                                                             : CODE_DATA_ACK;
                                end else begin
                                    r_next.data = r_reg.shift;
                                    r_next.code = r_reg.ack_en ? CODE_RDATA_ACK
                                                               : CODE_RDATA_NACK;
                                end
                            end else begin
                                r_next.bitn = r_reg.bitn + 4'd1;
                                if (r_reg.tx) begin
                                    r_next.shift = {r_reg.shift[6:0], 1'b0};
                                end
                            end
                        end
                    endcase
                end
            end
            ST_HOLD: begin
                // parked until software clears done; clock held low except after lost arbitration
                if (!r_reg.done) begin
                    r_next.ph = 2'd0;
                    if (!r_reg.owner) begin
                        r_next.state = r_reg.start_req ? ST_WAIT_FREE : ST_IDLE;
                    end else if (r_reg.stop_req) begin
                        r_next.state = ST_STOP;
                    end else if (r_reg.start_req) begin
                        r_next.state = ST_RSTART;
                    end else begin
                        r_next.state = ST_BYTE;
                        r_next.bitn  = 4'd0;
                        r_next.shift = r_reg.data;
                        r_next.tx    = r_reg.addr_phase || !r_reg.rx_mode;
                        if (r_reg.addr_phase) begin
                            r_next.rx_mode = r_reg.data[0];
                        end
                    end
                end
            end
            ST_STOP: begin
                // data low, clock up, then data up while clock high
                if (tick) begin
                    unique case (r_reg.ph)
                        2'd0: r_next.sda_drive = 1'b1;
                        2'd1: r_next.scl_drive = 1'b0;
                        2'd2: ;
                        2'd3: begin
                            r_next.sda_drive = 1'b0;
                            r_next.stop_req  = 1'b0;
                            r_next.owner     = 1'b0;
                            r_next.rx_mode   = 1'b0;
                            r_next.state = r_reg.start_req ? ST_WAIT_FREE : ST_IDLE;
                        end
                    endcase
                end
            end
        endcase

        // disabled interface lets go of the bus at once
        if (!r_reg.enable) begin
            r_next.state     = ST_IDLE;
            r_next.scl_drive = 1'b0;
            r_next.sda_drive = 1'b0;
            r_next.owner     = 1'b0;
            r_next.rx_mode   = 1'b0;
        end

        // hardware set wins over a same-cycle clear
        r_next.irq_status = r_next.irq_status | ev;
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '{
                state:      ST_IDLE,
                ph:         2'd0,
                cnt:        12'h000,
                bitn:       4'h0,
                shift:      8'h00,
                tx:         1'b1,
                nack:       1'b0,
                done:       CONTROL_RESET[BIT_DONE],
                ack_en:     CONTROL_RESET[BIT_ACK_EN],
                start_req:  CONTROL_RESET[BIT_START],
                stop_req:   CONTROL_RESET[BIT_STOP],
                wcol:       CONTROL_RESET[BIT_WCOL],
                enable:     CONTROL_RESET[BIT_ENABLE],
                irq_en:     CONTROL_RESET[BIT_IRQ_EN],
                code:       CODE_IDLE,
                presc:      PRESC_RESET,
                data:       DATA_RESET,
                irq_status: '0,
                irq_mask:   MASK_RESET,
                ack:        1'b0,
                rdata:      32'h0000_0000,
                busy:       1'b0,
                scl_prev:   1'b1,
                sda_prev:   1'b1,
                owner:      1'b0,
                addr_phase: 1'b0,
                rx_mode:    1'b0,
                scl_drive:  1'b0,
                sda_drive:  1'b0
            };
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // outputs: open drain only ever pulls low
    assign waitrequest = (read || write) && !r_reg.ack;
    assign readdata    = r_reg.rdata;
    assign scl_out     = 1'b0;
    assign sda_out     = 1'b0;
    assign scl_oe      = r_reg.scl_drive;
    assign sda_oe      = r_reg.sda_drive;
    // done level when enabled, plus masked sticky events
    assign irq = (r_reg.irq_en && r_reg.done) ||
                 |(r_reg.irq_status & r_reg.irq_mask);

endmodule : two_wire_master

`default_nettype wire

/* verilog/two_wire_sync.sv */
// two-flop synchroniser for the bus pins.
// assumes inputs are asynchronous to clk; only stage two is visible.
`timescale 1ns/1ps
`default_nettype none

module two_wire_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_s;

    sync_s r_reg;
    sync_s r_next;

    // ==========================================================
    // stage one feeds stage two only
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    // released lines idle high, so reset to ones
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '{s1: '1, s2: '1};
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.s2;

endmodule : two_wire_sync

`default_nettype wire
